// File: core/flash_pe_mode_host.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
module flash_pe_mode_host
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             irq,
  output logic      [23:0] dev_addr,
  output logic      [15:0] dev_wdata,
  output logic             dev_wr,
  output logic             dev_rd,
  output logic             dev_wide,
  input  wire logic [15:0] dev_rdata
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  flash_pe_pkg::seq_state_t state;
  flash_pe_pkg::seq_state_t next_state;
  logic [1:0]  cmd;
  logic [1:0]  next_cmd;
  logic        lowv;
  logic        next_lowv;
  logic [2:0]  step;
  logic [2:0]  next_step;
  logic [7:0]  operand;
  logic [7:0]  next_operand;
  logic [7:0]  entry_seen;
  logic [7:0]  next_entry_seen;
  logic        prot_seen;
  logic        next_prot_seen;
  logic [1:0]  int_stat;
  logic [1:0]  next_int_stat;
  logic [1:0]  int_mask;
  logic [1:0]  next_int_mask;
  logic [7:0]  next_reg_rdata;
  logic        next_irq;
  logic [23:0] next_dev_addr;
  logic [15:0] next_dev_wdata;
  logic        next_dev_wr;
  logic        next_dev_rd;
  logic        next_dev_wide;
  logic        ev_done;
  logic        ev_err;
  logic        timer_load;
  logic [15:0] timer_cycles;
  logic        timer_expired;
  logic [10:0] cur_step;

  // ---------------------------------------------------------------
  // step tables
  // ---------------------------------------------------------------
  function automatic logic [7:0] mode_byte(input logic [2:0] ms,
                                           input logic       romdis,
                                           input logic       lv);
    logic [7:0] b;
    b = 8'h00;
    b[flash_pe_pkg::MS0_BIT]    = ms[0];
    b[flash_pe_pkg::MS1_BIT]    = ms[1];
    b[flash_pe_pkg::MS2_BIT]    = ms[2];
    b[flash_pe_pkg::ROMDIS_BIT] = romdis;
    b[flash_pe_pkg::LOWV_BIT]   = lv;
    return b;
  endfunction

  function automatic logic [10:0] step_of(input logic [1:0] c,
                                          input logic [2:0] i,
                                          input logic       lv);
    logic [10:0] s;
    s = {flash_pe_pkg::OP_END, 8'h00};
    case (c)
      flash_pe_pkg::CMD_ENTER_ROM:
        case (i)
          3'h0: s = {flash_pe_pkg::OP_ENTRY, flash_pe_pkg::ENTRY_ROM};
          3'h1: s = {flash_pe_pkg::OP_MODE,
                     mode_byte(flash_pe_pkg::MODE_DISCH1, 1'b0, lv)};
          3'h2: s = {flash_pe_pkg::OP_WAIT_ONE, 8'h00};
          3'h3: s = {flash_pe_pkg::OP_MODE,
                     mode_byte(flash_pe_pkg::MODE_DISCH2, 1'b0, lv)};
          3'h4: s = {flash_pe_pkg::OP_MODE,
                     mode_byte(flash_pe_pkg::MODE_ROM_PE, 1'b0, lv)};
          3'h5: s = {flash_pe_pkg::OP_WAIT_TWO, 8'h00};
          default: s = {flash_pe_pkg::OP_END, 8'h00};
        endcase
      flash_pe_pkg::CMD_LEAVE_ROM:
        case (i)
          3'h0: s = {flash_pe_pkg::OP_MODE,
                     mode_byte(flash_pe_pkg::MODE_DISCH2, 1'b0, lv)};
          3'h1: s = {flash_pe_pkg::OP_WAIT_ONE, 8'h00};
          3'h2: s = {flash_pe_pkg::OP_MODE,
                     mode_byte(flash_pe_pkg::MODE_DISCH1, 1'b0, lv)};
          3'h3: s = {flash_pe_pkg::OP_MODE,
                     mode_byte(flash_pe_pkg::MODE_READ, 1'b1, lv)};
          3'h4: s = {flash_pe_pkg::OP_WAIT_TWO, 8'h00};
          3'h5: s = {flash_pe_pkg::OP_ENTRY, flash_pe_pkg::ENTRY_NONE};
          default: s = {flash_pe_pkg::OP_END, 8'h00};
        endcase
      flash_pe_pkg::CMD_ENTER_DF:
        case (i)
          3'h0: s = {flash_pe_pkg::OP_ENTRY, flash_pe_pkg::ENTRY_DF};
          3'h1: s = {flash_pe_pkg::OP_MODE,
                     mode_byte(flash_pe_pkg::MODE_DF_PE, 1'b0, lv)};
          default: s = {flash_pe_pkg::OP_END, 8'h00};
        endcase
      default:
        case (i)
          3'h0: s = {flash_pe_pkg::OP_MODE,
                     mode_byte(flash_pe_pkg::MODE_READ, 1'b1, lv)};
          3'h1: s = {flash_pe_pkg::OP_WAIT_TWO, 8'h00};
          3'h2: s = {flash_pe_pkg::OP_ENTRY, flash_pe_pkg::ENTRY_NONE};
          default: s = {flash_pe_pkg::OP_END, 8'h00};
        endcase
    endcase
    return s;
  endfunction

  assign cur_step = step_of(cmd, step, lowv);

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    next_state      = state;
    next_step       = step;
    next_operand    = operand;
    next_entry_seen = entry_seen;
    next_prot_seen  = prot_seen;
    next_dev_addr   = dev_addr;
    next_dev_wdata  = dev_wdata;
    next_dev_wr     = 1'b0;
    next_dev_rd     = 1'b0;
    next_dev_wide   = dev_wide;
    ev_done         = 1'b0;
    ev_err          = 1'b0;
    timer_load      = 1'b0;
    timer_cycles    = flash_pe_pkg::WAIT_ONE_CYCLES;
    case (state)
      flash_pe_pkg::S_IDLE:
        if (reg_wr && reg_addr == flash_pe_pkg::REG_CTRL
            && reg_wdata[flash_pe_pkg::CTRL_START_BIT])
        begin
          next_step  = 3'h0;
          next_state = flash_pe_pkg::S_FETCH;
        end
      flash_pe_pkg::S_FETCH:
      begin
        next_operand = cur_step[7:0];
        case (cur_step[10:8])
          flash_pe_pkg::OP_ENTRY: next_state = flash_pe_pkg::S_ENT_WR;
          flash_pe_pkg::OP_MODE:  next_state = flash_pe_pkg::S_KEY;
          flash_pe_pkg::OP_WAIT_ONE:
          begin
            timer_load   = 1'b1;
            timer_cycles = flash_pe_pkg::WAIT_ONE_CYCLES;
            next_state   = flash_pe_pkg::S_WAIT;
          end
          flash_pe_pkg::OP_WAIT_TWO:
          begin
            timer_load   = 1'b1;
            timer_cycles = flash_pe_pkg::WAIT_TWO_CYCLES;
            next_state   = flash_pe_pkg::S_WAIT;
          end
          default:
          begin
            ev_done    = 1'b1;
            next_state = flash_pe_pkg::S_IDLE;
          end
        endcase
      end
      flash_pe_pkg::S_ENT_WR:
      begin
        next_dev_addr  = flash_pe_pkg::ADDR_PE_ENTRY;
        next_dev_wdata = {flash_pe_pkg::ENTRY_WRITE_KEY, operand};
        next_dev_wide  = 1'b1;
        next_dev_wr    = 1'b1;
        next_state     = flash_pe_pkg::S_ENT_RD;
      end
      flash_pe_pkg::S_ENT_RD:
      begin
        next_dev_rd = 1'b1;
        next_state  = flash_pe_pkg::S_ENT_LAT;
      end
      flash_pe_pkg::S_ENT_LAT:
        next_state = flash_pe_pkg::S_ENT_CHK;
      flash_pe_pkg::S_ENT_CHK:
      begin
        next_entry_seen = dev_rdata[7:0];
        // key byte reads 00h and b6..b1 read zero
        if (dev_rdata != {flash_pe_pkg::ENTRY_KEY_READ, operand})
        begin
          ev_err     = 1'b1;
          next_state = flash_pe_pkg::S_IDLE;
        end
        else
        begin
          next_step  = step + 3'h1;
          next_state = flash_pe_pkg::S_FETCH;
        end
      end
      flash_pe_pkg::S_KEY:
      begin
        next_dev_addr  = flash_pe_pkg::ADDR_UNLOCK_KEY;
        next_dev_wdata = {8'h00, flash_pe_pkg::UNLOCK_KEY_VAL};
        next_dev_wide  = 1'b0;
        next_dev_wr    = 1'b1;
        next_state     = flash_pe_pkg::S_VAL_ONE;
      end
      flash_pe_pkg::S_VAL_ONE:
      begin
        next_dev_addr  = flash_pe_pkg::ADDR_OP_MODE;
        next_dev_wdata = {8'h00, operand};
        next_dev_wr    = 1'b1;
        next_state     = flash_pe_pkg::S_VAL_INV;
      end
      flash_pe_pkg::S_VAL_INV:
      begin
        next_dev_wdata = {8'h00, ~operand};
        next_dev_wr    = 1'b1;
        next_state     = flash_pe_pkg::S_VAL_TWO;
      end
      flash_pe_pkg::S_VAL_TWO:
      begin
        next_dev_wdata = {8'h00, operand};
        next_dev_wr    = 1'b1;
        next_state     = flash_pe_pkg::S_STAT_RD;
      end
      flash_pe_pkg::S_STAT_RD:
      begin
        next_dev_addr = flash_pe_pkg::ADDR_UNLOCK_STAT;
        next_dev_rd   = 1'b1;
        next_state    = flash_pe_pkg::S_STAT_CHK;
      end
      flash_pe_pkg::S_STAT_CHK:
        next_state = flash_pe_pkg::S_WAIT;
      flash_pe_pkg::S_WAIT:
      begin
        // wait entered from the status read checks the flag on the data cycle
        if (dev_rd == 1'b0 && dev_addr == flash_pe_pkg::ADDR_UNLOCK_STAT
            && !timer_load)
        begin
          next_prot_seen =
            dev_rdata[flash_pe_pkg::PROT_ERR_BIT];
          next_dev_addr  = flash_pe_pkg::ADDR_OP_MODE;
          if (dev_rdata[flash_pe_pkg::PROT_ERR_BIT])
          begin
            ev_err     = 1'b1;
            next_state = flash_pe_pkg::S_IDLE;
          end
          else
          begin
            next_step  = step + 3'h1;
            next_state = flash_pe_pkg::S_FETCH;
          end
        end
        else if (timer_expired)
        begin
          next_step  = step + 3'h1;
          next_state = flash_pe_pkg::S_FETCH;
        end
      end
      default:
        next_state = flash_pe_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state      <= flash_pe_pkg::S_IDLE;
      step       <= 3'h0;
      operand    <= 8'h00;
      entry_seen <= 8'h00;
      prot_seen  <= 1'b0;
      dev_addr   <= 24'h00_0000;
      dev_wdata  <= 16'h0000;
      dev_wr     <= 1'b0;
      dev_rd     <= 1'b0;
      dev_wide   <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      step       <= next_step;
      operand    <= next_operand;
      entry_seen <= next_entry_seen;
      prot_seen  <= next_prot_seen;
      dev_addr   <= next_dev_addr;
      dev_wdata  <= next_dev_wdata;
      dev_wr     <= next_dev_wr;
      dev_rd     <= next_dev_rd;
      dev_wide   <= next_dev_wide;
    end
  end

  flash_wait_timer #(.WIDTH(flash_pe_pkg::TIMER_W)) u_timer
  (
    .ref_clk (ref_clk),
    .reset   (reset),
    .load    (timer_load),
    .cycles  (timer_cycles),
    .expired (timer_expired)
  );

  // ---------------------------------------------------------------
  // software registers and interrupt
  // ---------------------------------------------------------------
  always_comb
  begin
    next_cmd       = cmd;
    next_lowv      = lowv;
    next_int_mask  = int_mask;
    next_int_stat  = int_stat;
    next_reg_rdata = 8'h00;
    // command bits only change while idle
    if (reg_wr && reg_addr == flash_pe_pkg::REG_CTRL
        && state == flash_pe_pkg::S_IDLE)
    begin
      next_cmd  = reg_wdata[1:0];
      next_lowv = reg_wdata[flash_pe_pkg::CTRL_LOWV_BIT];
    end
    if (reg_wr && reg_addr == flash_pe_pkg::REG_INT_MASK)
      next_int_mask = reg_wdata[1:0];
    if (reg_rd)
      case (reg_addr)
        flash_pe_pkg::REG_CTRL:
          next_reg_rdata = {5'h00, lowv, cmd};
        flash_pe_pkg::REG_STATUS:
          next_reg_rdata = {4'h0, prot_seen,
                            entry_seen[flash_pe_pkg::ENTRY_DF_BIT],
                            entry_seen[flash_pe_pkg::ENTRY_ROM_BIT],
                            state != flash_pe_pkg::S_IDLE};
        flash_pe_pkg::REG_INT_STATUS:
        begin
          next_reg_rdata = {6'h00, int_stat};
          next_int_stat  = 2'h0;
        end
        flash_pe_pkg::REG_INT_MASK:
          next_reg_rdata = {6'h00, int_mask};
        default:
          next_reg_rdata = 8'h00;
      endcase
    // a new event wins over the clearing read
    if (ev_done)
      next_int_stat[flash_pe_pkg::INT_DONE_BIT] = 1'b1;
    if (ev_err)
      next_int_stat[flash_pe_pkg::INT_ERR_BIT] = 1'b1;
    next_irq = |(next_int_stat & int_mask);
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cmd       <= 2'h0;
      lowv      <= 1'b0;
      int_mask  <= 2'h0;
      int_stat  <= 2'h0;
      reg_rdata <= 8'h00;
      irq       <= 1'b0;
    end
    else
    begin
      cmd       <= next_cmd;
      lowv      <= next_lowv;
      int_mask  <= next_int_mask;
      int_stat  <= next_int_stat;
      reg_rdata <= next_reg_rdata;
      irq       <= next_irq;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic        mode_wr;
  logic [2:0]  wr_ms;
  logic [15:0] gap;
  logic [2:0]  prev_ms;

  assign mode_wr = dev_wr && dev_addr == flash_pe_pkg::ADDR_OP_MODE;
  assign wr_ms   = {dev_wdata[flash_pe_pkg::MS2_BIT],
                    dev_wdata[flash_pe_pkg::MS1_BIT],
                    dev_wdata[flash_pe_pkg::MS0_BIT]};

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      gap     <= 16'h0000;
      prev_ms <= 3'h0;
    end
    else if (mode_wr && (state == flash_pe_pkg::S_STAT_RD))
    begin
      gap     <= 16'h0000;
      prev_ms <= wr_ms;
    end
    else if (gap != 16'hffff)
      gap <= gap + 16'h0001;
  end

  AST_ENTRY_KEY: assert property (@(posedge ref_clk) disable iff (reset)
    dev_wr && dev_addr == flash_pe_pkg::ADDR_PE_ENTRY |->
      dev_wide && dev_wdata[15:8] == 8'haa)
    else $error("entry write without key or not 16-bit");

  AST_ENTRY_CODE: assert property (@(posedge ref_clk) disable iff (reset)
    dev_wr && dev_addr == flash_pe_pkg::ADDR_PE_ENTRY |->
      dev_wdata[7:0] inside {8'h00, 8'h01, 8'h80})
    else $error("entry write with illegal low byte");

  AST_ENTRY_CONFIRM: assert property (@(posedge ref_clk) disable iff (reset)
    dev_wr && dev_addr == flash_pe_pkg::ADDR_PE_ENTRY |=>
      dev_rd && dev_addr == flash_pe_pkg::ADDR_PE_ENTRY)
    else $error("entry write not read back");

  AST_UNLOCK_ORDER: assert property (@(posedge ref_clk) disable iff (reset)
    dev_wr && dev_addr == flash_pe_pkg::ADDR_UNLOCK_KEY
      && dev_wdata[7:0] == 8'ha5 |=>
      mode_wr ##1 (mode_wr && dev_wdata[7:0] == ~$past(dev_wdata[7:0]))
      ##1 (mode_wr && dev_wdata[7:0] == $past(dev_wdata[7:0], 2)))
    else $error("unlock sequence out of order");

  AST_NO_BARE_MODE: assert property (@(posedge ref_clk) disable iff (reset)
    mode_wr |-> $past(dev_addr) == flash_pe_pkg::ADDR_UNLOCK_KEY
      || $past(dev_addr, 2) == flash_pe_pkg::ADDR_UNLOCK_KEY
      || $past(dev_addr, 3) == flash_pe_pkg::ADDR_UNLOCK_KEY)
    else $error("mode write without unlock key");

  AST_MODE_LEGAL: assert property (@(posedge ref_clk) disable iff (reset)
    mode_wr && state != flash_pe_pkg::S_STAT_RD
      && state != flash_pe_pkg::S_VAL_TWO |->
      wr_ms inside {3'h0, 3'h2, 3'h3, 3'h5, 3'h7})
    else $error("prohibited mode select code");

  AST_ROM_DISABLE: assert property (
    @(posedge ref_clk) disable iff (reset)
    mode_wr && state == flash_pe_pkg::S_VAL_INV |->
      dev_wdata[flash_pe_pkg::ROMDIS_BIT] == (wr_ms == 3'h0))
    else $error("rom disable bit wrong for mode");

  AST_LOW_VOLTAGE: assert property (
    @(posedge ref_clk) disable iff (reset)
    mode_wr && state == flash_pe_pkg::S_VAL_INV |->
      dev_wdata[flash_pe_pkg::LOWV_BIT] == lowv)
    else $error("low-voltage bit differs from setting");

  AST_WAIT_ONE: assert property (
    @(posedge ref_clk) disable iff (reset)
    mode_wr && state == flash_pe_pkg::S_STAT_RD && wr_ms == 3'h7
      && prev_ms == 3'h3 |-> gap >= flash_pe_pkg::WAIT_ONE_CYCLES)
    else $error("first transition wait too short");

  // the clearing entry write only follows read mode after the long wait
  AST_WAIT_TWO: assert property (
    @(posedge ref_clk) disable iff (reset)
    dev_wr && dev_addr == flash_pe_pkg::ADDR_PE_ENTRY
      && dev_wdata[7:0] == flash_pe_pkg::ENTRY_NONE
      && prev_ms == flash_pe_pkg::MODE_READ
      |-> gap >= flash_pe_pkg::WAIT_TWO_CYCLES)
    else $error("second transition wait too short");

endmodule

// File: include/flash_pe_pkg.sv
package flash_pe_pkg;

  // ---------------------------------------------------------------
  // device register map (byte addresses on the flash register bus)
  // ---------------------------------------------------------------
  localparam logic [23:0] ADDR_UNLOCK_KEY  = 24'h7f_c0c0;
  localparam logic [23:0] ADDR_UNLOCK_STAT = 24'h7f_c0c1;
  localparam logic [23:0] ADDR_OP_MODE     = 24'h7f_ff80;
  localparam logic [23:0] ADDR_PE_ENTRY    = 24'h7f_ffb2;

  // ---------------------------------------------------------------
  // device field layout and codes
  // ---------------------------------------------------------------
  localparam logic [7:0]  ENTRY_WRITE_KEY  = 8'haa;
  localparam logic [7:0]  ENTRY_KEY_READ   = 8'h00;
  localparam logic [7:0]  ENTRY_NONE       = 8'h00;
  localparam logic [7:0]  ENTRY_ROM        = 8'h01;
  localparam logic [7:0]  ENTRY_DF         = 8'h80;
  localparam int          ENTRY_ROM_BIT    = 0;
  localparam int          ENTRY_DF_BIT     = 7;
  localparam logic [7:0]  UNLOCK_KEY_VAL   = 8'ha5;
  localparam int          PROT_ERR_BIT     = 0;
  localparam int          MS0_BIT          = 1;
  localparam int          ROMDIS_BIT       = 3;
  localparam int          MS1_BIT          = 4;
  localparam int          LOWV_BIT         = 6;
  localparam int          MS2_BIT          = 7;
  localparam logic [2:0]  MODE_READ        = 3'h0;
  localparam logic [2:0]  MODE_DF_PE       = 3'h2;
  localparam logic [2:0]  MODE_DISCH1      = 3'h3;
  localparam logic [2:0]  MODE_ROM_PE      = 3'h5;
  localparam logic [2:0]  MODE_DISCH2      = 3'h7;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          CLK_PERIOD_NS    = 4;
  localparam int          T_WAIT_ONE_NS    = 1000;
  localparam int          T_WAIT_TWO_NS    = 10000;
  localparam int          TIMER_W          = 16;
  localparam logic [TIMER_W-1:0] WAIT_ONE_CYCLES = TIMER_W'(
    (T_WAIT_ONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] WAIT_TWO_CYCLES = TIMER_W'(
    (T_WAIT_TWO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // host register map (own port)
  // ---------------------------------------------------------------
  localparam logic [3:0]  REG_CTRL         = 4'h0;
  localparam logic [3:0]  REG_STATUS       = 4'h1;
  localparam logic [3:0]  REG_INT_STATUS   = 4'h2;
  localparam logic [3:0]  REG_INT_MASK     = 4'h3;
  localparam int          CTRL_LOWV_BIT    = 2;
  localparam int          CTRL_START_BIT   = 7;
  localparam int          INT_DONE_BIT     = 0;
  localparam int          INT_ERR_BIT      = 1;

  // commands
  localparam logic [1:0]  CMD_ENTER_ROM    = 2'h0;
  localparam logic [1:0]  CMD_LEAVE_ROM    = 2'h1;
  localparam logic [1:0]  CMD_ENTER_DF     = 2'h2;
  localparam logic [1:0]  CMD_LEAVE_DF     = 2'h3;

  // sequence step opcodes
  localparam logic [2:0]  OP_END           = 3'h0;
  localparam logic [2:0]  OP_ENTRY         = 3'h1;
  localparam logic [2:0]  OP_MODE          = 3'h2;
  localparam logic [2:0]  OP_WAIT_ONE      = 3'h3;
  localparam logic [2:0]  OP_WAIT_TWO      = 3'h4;

  typedef enum logic [12:0] {
    S_IDLE     = 13'h0001,
    S_FETCH    = 13'h0002,
    S_ENT_WR   = 13'h0004,
    S_ENT_RD   = 13'h0008,
    S_ENT_LAT  = 13'h0010,
    S_ENT_CHK  = 13'h0020,
    S_KEY      = 13'h0040,
    S_VAL_ONE  = 13'h0080,
    S_VAL_INV  = 13'h0100,
    S_VAL_TWO  = 13'h0200,
    S_STAT_RD  = 13'h0400,
    S_STAT_CHK = 13'h0800,
    S_WAIT     = 13'h1000
  } seq_state_t;

endpackage

// File: core/flash_wait_timer.sv
`timescale 1ns/1ns
module flash_wait_timer
#(
  parameter int WIDTH = 16
)
(
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] cycles,
  output logic                  expired
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  always_comb
  begin
    next_count = count;
    if (load)
      next_count = cycles;
    else if (count != '0)
      next_count = count - WIDTH'(1);
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      count <= '0;
    else
      count <= next_count;
  end

  // a load takes priority, so the wait never ends early
  assign expired = (count == '0) && !load;

endmodule

// File: test/flash_dev_model.sv
`timescale 1ns/1ns
module flash_dev_model
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [23:0] dev_addr,
  input  wire logic [15:0] dev_wdata,
  input  wire logic        dev_wr,
  input  wire logic        dev_rd,
  input  wire logic        dev_wide,
  input  wire logic [1:0]  fault,
  output logic      [15:0] dev_rdata
);
  logic [7:0] entry, mode, val;
  logic [1:0] step;
  logic       prot_err;
  wire  [7:0] wd = dev_wdata[7:0];
  // no code fetch passes this link: running from ram is software's
  // ---------------------------------------------------------------
  // fault[0] ignores entry writes, fault[1] never unlocks
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    dev_rdata <= ~dev_rdata; // released bus never holds a value
    if (reset)
    begin
      entry <= 8'h00;
      mode  <= 8'h00;
      prot_err <= 1'b0;
      step  <= 2'h0;
    end
    else if (dev_wr && dev_addr == flash_pe_pkg::ADDR_PE_ENTRY && dev_wide
             && !fault[0] && dev_wdata[15:8] == 8'haa)
    begin
      if (wd == 8'h00)
        entry <= 8'h00;
      else if (entry == 8'h00 && (wd == 8'h01 || wd == 8'h80))
        entry <= wd;
    end
    else if (dev_wr && dev_addr == flash_pe_pkg::ADDR_UNLOCK_KEY)
      step <= (wd == 8'ha5 && !fault[1]) ? 2'h1 : 2'h0;
    else if (dev_wr && dev_addr == flash_pe_pkg::ADDR_OP_MODE)
    begin
      step <= 2'h0;
      if (step == 2'h1)
      begin
        val  <= wd;
        step <= 2'h2;
      end
      else if (step == 2'h2 && wd == ~val)
        step <= 2'h3;
      else if (step == 2'h3 && wd == val)
      begin
        mode <= val & 8'hda;
        prot_err <= 1'b0;
      end
      else
        prot_err <= 1'b1;
    end
    else if (dev_rd && dev_addr == flash_pe_pkg::ADDR_PE_ENTRY)
      dev_rdata <= {8'h00, entry};
    else if (dev_rd && dev_addr == flash_pe_pkg::ADDR_UNLOCK_STAT)
      dev_rdata <= {15'h0000, prot_err};
  end
endmodule

// File: test/flash_pe_mode_control_bench.sv
`timescale 1ns/1ns
module flash_pe_mode_control_bench;
  logic        ref_clk, reset, reg_wr, reg_rd, irq, dev_wr, dev_rd, dev_wide;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, d;
  logic [23:0] dev_addr;
  logic [15:0] dev_wdata, dev_rdata;
  logic [1:0]  fault;
  int          fails, tests_run, n;
  // ctrl byte, expected mode register, expected entry register
  logic [23:0] rows [4] = '{24'h84_c201, 24'h81_0800, 24'h82_1080,
                            24'h87_4800};
  flash_pe_mode_host dut (.ref_clk(ref_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr),
    .dev_rd(dev_rd), .dev_wide(dev_wide), .dev_rdata(dev_rdata));
  flash_dev_model model (.ref_clk(ref_clk), .reset(reset),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr),
    .dev_rd(dev_rd), .dev_wide(dev_wide), .fault(fault),
    .dev_rdata(dev_rdata));
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task tally_and_finish;
    $display("mismatches %0d of %0d checks", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      fails++;
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // start a command, bounded wait for irq, check the event bits
  task run(input logic [7:0] c, input logic [7:0] ev);
    wr(4'h0, c);
    n = 0;
    while (irq !== 1'b1 && n < 4000)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (irq !== 1'b1)
    begin
      fails++;
      tally_and_finish;
    end
    rd(4'h2, d);
    chk(d, ev);
  endtask
  initial
  begin
    {reset, reg_wr, reg_rd, reg_addr, reg_wdata, fault} = 0;
    reset = 1'b1;
    fails = 0;
    tests_run = 0;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    rd(4'h1, d);
    chk(d, 8'h00);
    rd(4'h3, d);
    chk(d, 8'h00);
    rd(4'h9, d);
    chk(d, 8'h00);
    wr(4'h3, 8'h03);
    for (int i = 0; i < 4; i++)
    begin
      run(rows[i][23:16], 8'h01);
      chk(model.mode, rows[i][15:8]);
      chk(model.entry, rows[i][7:0]);
      rd(4'h1, d);
      chk(d, {5'h00, rows[i][7], rows[i][0], 1'b0});
    end
    // a start while busy must be dropped
    wr(4'h0, 8'h82);
    run(8'h81, 8'h01);
    chk(model.mode, 8'h10);
    chk(model.entry, 8'h80);
    rd(4'h0, d);
    chk(d, 8'h02);
    rd(4'h2, d);
    chk(d, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h0, 8'h83);
    repeat (3000) @(posedge ref_clk);
    chk({7'h00, irq}, 8'h00);
    rd(4'h2, d);
    chk(d, 8'h01);
    wr(4'h3, 8'h03);
    fault <= 2'h1;
    run(8'h82, 8'h02);
    chk(model.mode, 8'h08);
    fault <= 2'h2;
    run(8'h80, 8'h02);
    rd(4'h1, d);
    chk(d, 8'h0a);
    chk(model.mode, 8'h08);
    // reset in the middle of a sequence, then a clean restart
    wr(4'h0, 8'h84);
    repeat (4) @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    fault <= 2'h0;
    chk({7'h00, irq}, 8'h00);
    rd(4'h1, d);
    chk(d, 8'h00);
    rd(4'h0, d);
    chk(d, 8'h00);
    wr(4'h3, 8'h03);
    run(8'h82, 8'h01);
    chk(model.mode, 8'h10);
    tally_and_finish;
  end
endmodule
